// *** bench/apc_adc_ctrl_chk.sv ***
// checker for the adc path control top, bound to its ports
// assumes one clock and an async active-low reset
module apc_adc_ctrl_chk (
	input wire mclk_i,
	input wire rstn_i,
	input wire ctrl_port_mode_i,
	input wire adc_left_mute_i,
	input wire adc_right_mute_i,
	input wire adc_power_down_i,
	input wire dac_power_down_i,
	input wire left_highpass_defeat_i,
	input wire mode_byte_read_i,
	input wire clk_alive_i,
	input wire sample_valid_i,
	input wire [19:0] left_sample_i,
	input wire sample_valid_o,
	input wire [19:0] left_sample_o,
	input wire [19:0] right_sample_o,
	input wire [2:0] left_peak_level_o,
	input wire [2:0] right_peak_level_o,
	input wire adc_powered_down_o,
	input wire dac_powered_down_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	left_mute_a: assert property (sample_valid_o && $past(adc_left_mute_i) && $past(ctrl_port_mode_i)
		|-> left_sample_o == 20'h00000) else $error("left not muted");
	right_mute_a: assert property (sample_valid_o && $past(adc_right_mute_i) && $past(ctrl_port_mode_i)
		|-> right_sample_o == 20'h00000) else $error("right not muted");
	valid_cause_a: assert property (sample_valid_o |-> $past(sample_valid_i)) else $error("stray valid");
	adc_down_a: assert property ((ctrl_port_mode_i && adc_power_down_i)[*3]
		|-> adc_powered_down_o) else $error("adc not down");
	dac_alone_a: assert property ((ctrl_port_mode_i && !dac_power_down_i && clk_alive_i)[*4]
		|-> !dac_powered_down_o) else $error("dac went down");
	alone_peak_a: assert property ((!ctrl_port_mode_i)[*3]
		|-> left_peak_level_o == 3'h0 && right_peak_level_o == 3'h0) else $error("peak in stand-alone");
	peak_clear_a: assert property (!sample_valid_i ##1 mode_byte_read_i && !sample_valid_i ##1 !sample_valid_i
		|=> left_peak_level_o == 3'h0 && right_peak_level_o == 3'h0) else $error("peak not cleared");
	peak_hold_a: assert property ((ctrl_port_mode_i && !mode_byte_read_i && !adc_powered_down_o)[*4]
		|-> left_peak_level_o >= $past(left_peak_level_o)) else $error("peak fell");
	clip_code_a: assert property (sample_valid_i && ctrl_port_mode_i && !adc_powered_down_o && !adc_power_down_i
		&& left_highpass_defeat_i && left_sample_i == 20'h7FFFF |-> ##2 left_peak_level_o == 3'h7)
		else $error("clip not coded");
endmodule // apc_adc_ctrl_chk
bind apc_adc_ctrl apc_adc_ctrl_chk chk_u (.*);

// *** bench/apc_host_model.sv ***
// host side model: issues the clearing read of the mode byte
// assumes the bench raises rd_req_i for one cycle just after an edge
module apc_host_model (
	input wire mclk_i,
	input wire rd_req_i,
	output reg mode_byte_read_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial mode_byte_read_o = 1'b0;
	// one-cycle read strobe, moved just past the edge like all stimulus
	always @(posedge mclk_i) mode_byte_read_o <= #1 rd_req_i;
endmodule // apc_host_model

// *** bench/tb.sv ***
// testbench for the adc path control top
// assumes the design files and apc_defs.vh are on the include path
`include "apc_defs.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	reg mclk_i = 1'b0, rstn_i = 1'b0, ctrl_port_mode_i = 1'b1, adc_left_mute_i = 1'b0, adc_right_mute_i = 1'b0;
	reg adc_power_down_i = 1'b0, dac_power_down_i = 1'b0, left_highpass_defeat_i = 1'b1, right_highpass_defeat_i = 1'b1;
	reg output_format_select_i = 1'b0, mute_on_zero_en_i = 1'b0, zero_cross_en_i = 1'b0, volume_en_i = 1'b0;
	reg cal_cmd_i = 1'b0, clk_alive_i = 1'b1, sample_valid_i = 1'b0, rd_req = 1'b0;
	reg [1:0] word_length_i = 2'h2, mute_ramp_rate_i = 2'h0;
	reg [19:0] left_sample_i = 20'h00000, right_sample_i = 20'h00000;
	wire mode_byte_read_i, sample_valid_o, output_format_i2s_o, adc_powered_down_o, dac_powered_down_o;
	wire codec_powered_down_o, cal_start_o, mute_on_zero_en_o, zero_cross_en_o, volume_en_o;
	wire [19:0] left_sample_o, right_sample_o;
	wire [2:0] left_peak_level_o, right_peak_level_o;
	wire [1:0] word_length_o, mute_ramp_rate_o;
	integer n_mismatch = 0, check_count = 0, i;
	always #5 mclk_i = ~mclk_i;
	apc_adc_ctrl dut_u (.*);
	apc_host_model host_u (.mclk_i(mclk_i), .rd_req_i(rd_req), .mode_byte_read_o(mode_byte_read_i));
	task chk(input [19:0] got, input [19:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task send(input [19:0] l, input [19:0] r);
		left_sample_i = l;
		right_sample_i = r;
		sample_valid_i = 1'b1;
		tick(1);
		sample_valid_i = 1'b0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog well past the expected nine thousand cycles
	initial begin
		#200000;
		n_mismatch = n_mismatch + 1;
		final_report;
	end
	initial begin
		tick(2);
		chk(codec_powered_down_o, 1'b1);
		tick(2);
		rstn_i = 1'b1;
		tick(3);
		chk(output_format_i2s_o, 1'b1);
		for (i = 0; i < 4; i = i + 1) begin
			{adc_right_mute_i, adc_left_mute_i} = i[1:0];
			send(20'h12345, 20'hEDCBA);
			chk(sample_valid_o, 1'b1);
			tick(1);
			chk(left_sample_o, i[0] ? 20'h00000 : 20'h12345);
			chk(right_sample_o, i[1] ? 20'h00000 : 20'hEDCBA);
		end
		{adc_right_mute_i, adc_left_mute_i} = 2'h0;
		// shorter words zero the unused low bits
		for (i = 0; i < 3; i = i + 1) begin
			word_length_i = i[1:0];
			send(20'h12345, 20'h12345);
			tick(1);
			chk(word_length_o, i[1:0]);
			chk(left_sample_o, 20'h12345 & ~((20'h00001 << (4 - 2 * i)) - 20'h00001));
		end
		send(20'h7FFFF, 20'hA5000);
		tick(2);
		chk(left_peak_level_o, `APC_LVL_CLIP);
		chk(right_peak_level_o, `APC_LVL_DB3);
		send(20'h00100, 20'h00100);
		tick(2);
		chk(left_peak_level_o, `APC_LVL_CLIP);
		chk(right_peak_level_o, `APC_LVL_DB3);
		rd_req = 1'b1;
		tick(1);
		rd_req = 1'b0;
		tick(3);
		chk({left_peak_level_o, right_peak_level_o}, 20'h00000);
		// just above -1 dB on the left, just above -6 dB on the right
		send(20'h72200, 20'h402A0);
		tick(2);
		chk(left_peak_level_o, `APC_LVL_DB1);
		chk(right_peak_level_o, `APC_LVL_DB6);
		// dc on both channels, filter only on the left
		left_highpass_defeat_i = 1'b0;
		left_sample_i = 20'h10000;
		right_sample_i = 20'h10000;
		sample_valid_i = 1'b1;
		for (i = 0; i < 8000; i = i + 1) begin
			tick(1);
			if (i == 200)
				chk(left_sample_o > 20'h0E000, 1'b1);
		end
		sample_valid_i = 1'b0;
		tick(1);
		chk(left_sample_o < 20'h01000, 1'b1);
		chk(right_sample_o, 20'h10000);
		cal_cmd_i = 1'b1;
		for (i = 0; i < 4 && cal_start_o !== 1'b1; i = i + 1)
			tick(1);
		chk(cal_start_o, 1'b1);
		cal_cmd_i = 1'b0;
		{output_format_select_i, mute_on_zero_en_i, mute_ramp_rate_i, zero_cross_en_i, volume_en_i} = 6'h3F;
		tick(2);
		chk({output_format_i2s_o, mute_on_zero_en_o, mute_ramp_rate_o, zero_cross_en_o, volume_en_o}, 6'h1F);
		adc_power_down_i = 1'b1;
		tick(3);
		chk({adc_powered_down_o, dac_powered_down_o}, 2'h2);
		send(20'h12345, 20'h12345);
		chk(sample_valid_o, 1'b0);
		tick(1);
		chk(left_sample_o, 20'h00000);
		{adc_power_down_i, dac_power_down_i} = 2'h1;
		tick(3);
		chk({adc_powered_down_o, dac_powered_down_o}, 2'h1);
		{dac_power_down_i, word_length_i} = 3'h1;
		tick(3);
		// settings must survive the clock-loss stop
		clk_alive_i = 1'b0;
		tick(995);
		chk(adc_powered_down_o, 1'b0);
		tick(10);
		chk(adc_powered_down_o, 1'b1);
		clk_alive_i = 1'b1;
		tick(3);
		chk({adc_powered_down_o, word_length_o}, 3'h1);
		ctrl_port_mode_i = 1'b0;
		adc_power_down_i = 1'b1;
		tick(3);
		send(20'h7FFFF, 20'h7FFFF);
		tick(3);
		chk({left_peak_level_o, right_peak_level_o}, 20'h00000);
		chk(right_sample_o != 20'h7FFFF, 1'b1);
		chk({word_length_o, output_format_i2s_o}, {`APC_WL_20, 1'b1});
		chk({mute_on_zero_en_o, mute_ramp_rate_o, zero_cross_en_o, volume_en_o}, 5'h10);
		chk(adc_powered_down_o, 1'b0);
		final_report;
	end
endmodule // tb

// *** rtl/apc_adc_ctrl.v ***
// adc path control and level monitor, top level
// assumes decimated 20-bit samples arrive with a one-cycle valid strobe,
// and a clock-alive level from the clock monitor in the analog domain
//
// Overview of operation
// - mute bit forces channel samples to zero
// - adc power-down leaves dac path alone
// - track peak level per channel, 3 bits
// - code clipping, -1..-6 dB, or below
// - mode byte read clears both peak fields
// - first-order highpass after decimation removes dc
// - corner 3.7 Hz at 48 kHz, scales
// - per-channel highpass defeat bit bypasses filter
// - 20-bit adc samples on separate port
// - word length 16/18/20, standalone fixed 20 I2S
// - individual power-down only in control-port mode
// - standalone: highpass always on, no peaks
// - mute on zero: standalone forced, else selectable
// - zero-cross and volume only in control-port mode
// - reset low holds device powered down
// - output format left-justified or I2S, I2S default
// - clock stopped 10 us powers down, keeps settings
`include "apc_defs.vh"
module apc_adc_ctrl (
	input wire mclk_i,
	input wire rstn_i,
	input wire ctrl_port_mode_i,
	input wire adc_left_mute_i,
	input wire adc_right_mute_i,
	input wire adc_power_down_i,
	input wire dac_power_down_i,
	input wire left_highpass_defeat_i,
	input wire right_highpass_defeat_i,
	input wire output_format_select_i,
	input wire [1:0] word_length_i,
	input wire mute_on_zero_en_i,
	input wire [1:0] mute_ramp_rate_i,
	input wire zero_cross_en_i,
	input wire volume_en_i,
	input wire cal_cmd_i,
	input wire mode_byte_read_i,
	input wire clk_alive_i,
	input wire sample_valid_i,
	input wire [`APC_SAMPLE_W-1:0] left_sample_i,
	input wire [`APC_SAMPLE_W-1:0] right_sample_i,
	output reg sample_valid_o,
	output reg [`APC_SAMPLE_W-1:0] left_sample_o,
	output reg [`APC_SAMPLE_W-1:0] right_sample_o,
	output reg [`APC_LEVEL_W-1:0] left_peak_level_o,
	output reg [`APC_LEVEL_W-1:0] right_peak_level_o,
	output reg output_format_i2s_o,
	output reg [1:0] word_length_o,
	output reg adc_powered_down_o,
	output reg dac_powered_down_o,
	output reg codec_powered_down_o,
	output reg cal_start_o,
	output reg mute_on_zero_en_o,
	output reg [1:0] mute_ramp_rate_o,
	output reg zero_cross_en_o,
	output reg volume_en_o
);
	// power states
	localparam ST_OFF = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_STOP = 3'b100;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`APC_CLKLOSS_W-1:0] loss_cnt_reg;
	reg cal_done_reg;
	reg cal_cmd_prev_reg;
	reg [`APC_SAMPLE_W-1:0] word_mask;

	// next values of the output flops
	reg sample_valid_next;
	reg [`APC_SAMPLE_W-1:0] left_sample_next;
	reg [`APC_SAMPLE_W-1:0] right_sample_next;
	reg [`APC_LEVEL_W-1:0] left_peak_level_next;
	reg [`APC_LEVEL_W-1:0] right_peak_level_next;
	reg output_format_i2s_next;
	reg [1:0] word_length_next;
	reg adc_powered_down_next;
	reg dac_powered_down_next;
	reg codec_powered_down_next;
	reg cal_start_next;
	reg mute_on_zero_en_next;
	reg [1:0] mute_ramp_rate_next;
	reg zero_cross_en_next;
	reg volume_en_next;

	wire running;
	wire adc_on;
	wire hp_byp_l;
	wire hp_byp_r;
	wire peak_en;
	wire in_valid;
	wire [`APC_SAMPLE_W-1:0] hp_l;
	wire [`APC_SAMPLE_W-1:0] hp_r;
	wire [`APC_LEVEL_W-1:0] pk_l;
	wire [`APC_LEVEL_W-1:0] pk_r;

	function [`APC_SAMPLE_W-1:0] apc_gate;
		input [`APC_SAMPLE_W-1:0] s;
		input mute;
		input [`APC_SAMPLE_W-1:0] mask;
		begin
			apc_gate = mute ? 20'h00000 : (s & mask);
		end
	endfunction

	assign running = (state_reg == ST_RUN);
	// individual adc power-down is a control-port feature only
	assign adc_on = running && !(ctrl_port_mode_i && adc_power_down_i);
	assign in_valid = sample_valid_i && adc_on;
	// standalone keeps the filter in, whatever the defeat inputs say
	assign hp_byp_l = ctrl_port_mode_i && left_highpass_defeat_i;
	assign hp_byp_r = ctrl_port_mode_i && right_highpass_defeat_i;
	assign peak_en = ctrl_port_mode_i;

	// the clock monitor watches for a 10 us gap in real time; here we also
	// time out the qualified alive level so a stuck monitor still powers down
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF: begin
				state_next = ST_RUN;
			end
			ST_RUN: begin
				if (!clk_alive_i && loss_cnt_reg >= `APC_CLKLOSS_CYC - 1)
					state_next = ST_STOP;
			end
			ST_STOP: begin
				if (clk_alive_i)
					state_next = ST_RUN;
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
	end

	always @* begin
		if (!ctrl_port_mode_i || word_length_i == `APC_WL_20)
			word_mask = 20'hFFFFF;
		else if (word_length_i == `APC_WL_18)
			word_mask = 20'hFFFFC;
		else
			word_mask = 20'hFFFF0;
	end

	// reset drives the whole block to power-down; settings live outside
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_OFF;
			loss_cnt_reg <= 11'h000;
			cal_done_reg <= 1'b0;
			cal_cmd_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (clk_alive_i || !running)
				loss_cnt_reg <= 11'h000;
			else if (loss_cnt_reg < `APC_CLKLOSS_CYC)
				loss_cnt_reg <= loss_cnt_reg + 11'h001;
			cal_cmd_prev_reg <= cal_cmd_i;
			if (running)
				cal_done_reg <= 1'b1;
		end
	end

	apc_highpass u_hp_left (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.bypass_i(hp_byp_l),
		.sample_valid_i(in_valid),
		.sample_i(left_sample_i),
		.sample_o(hp_l)
	);

	apc_highpass u_hp_right (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.bypass_i(hp_byp_r),
		.sample_valid_i(in_valid),
		.sample_i(right_sample_i),
		.sample_o(hp_r)
	);

	// level is measured on the raw sample, ahead of any limiting
	apc_peak_detect u_pk_left (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.enable_i(peak_en),
		.sample_valid_i(in_valid),
		.sample_i(left_sample_i),
		.clear_i(mode_byte_read_i),
		.level_o(pk_l)
	);

	apc_peak_detect u_pk_right (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.enable_i(peak_en),
		.sample_valid_i(in_valid),
		.sample_i(right_sample_i),
		.clear_i(mode_byte_read_i),
		.level_o(pk_r)
	);

	// sample path: strobes are refused while the adc is down
	always @* begin
		sample_valid_next = in_valid;
		left_sample_next = left_sample_o;
		right_sample_next = right_sample_o;
		if (in_valid) begin
			left_sample_next = apc_gate(hp_l, adc_left_mute_i, word_mask);
			right_sample_next = apc_gate(hp_r, adc_right_mute_i, word_mask);
		end else if (!adc_on) begin
			left_sample_next = 20'h00000;
			right_sample_next = 20'h00000;
		end
		if (peak_en) begin
			left_peak_level_next = pk_l;
			right_peak_level_next = pk_r;
		end else begin
			left_peak_level_next = `APC_LVL_LOW;
			right_peak_level_next = `APC_LVL_LOW;
		end
	end

	// mode dependent settings; stand-alone pins the features to fixed values
	always @* begin
		adc_powered_down_next = !adc_on;
		codec_powered_down_next = !running;
		if (ctrl_port_mode_i) begin
			// format bit is active-high for left-justified; clear means I2S
			output_format_i2s_next = !output_format_select_i;
			word_length_next = word_length_i;
			dac_powered_down_next = !running || dac_power_down_i;
			cal_start_next = running && cal_cmd_i && !cal_cmd_prev_reg;
			mute_on_zero_en_next = mute_on_zero_en_i;
			mute_ramp_rate_next = mute_ramp_rate_i;
			zero_cross_en_next = zero_cross_en_i;
			volume_en_next = volume_en_i;
		end else begin
			// stand-alone: fixed I2S at 20 bits, whole-codec power-down only
			output_format_i2s_next = 1'b1;
			word_length_next = `APC_WL_20;
			dac_powered_down_next = !running;
			// calibrates once, in the first running cycle after power-up
			cal_start_next = running && !cal_done_reg;
			mute_on_zero_en_next = 1'b1;
			mute_ramp_rate_next = 2'h0;
			zero_cross_en_next = 1'b0;
			volume_en_next = 1'b0;
		end
	end

	// sample and level outputs leave from flops, so pins never glitch
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sample_valid_o <= 1'b0;
			left_sample_o <= 20'h00000;
			right_sample_o <= 20'h00000;
			left_peak_level_o <= `APC_LVL_LOW;
			right_peak_level_o <= `APC_LVL_LOW;
		end else begin
			sample_valid_o <= sample_valid_next;
			left_sample_o <= left_sample_next;
			right_sample_o <= right_sample_next;
			left_peak_level_o <= left_peak_level_next;
			right_peak_level_o <= right_peak_level_next;
		end
	end

	// status and settings follow a mode change one cycle late
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_format_i2s_o <= 1'b1;
			word_length_o <= `APC_WL_20;
			adc_powered_down_o <= 1'b1;
			dac_powered_down_o <= 1'b1;
			codec_powered_down_o <= 1'b1;
			cal_start_o <= 1'b0;
			mute_on_zero_en_o <= 1'b0;
			mute_ramp_rate_o <= 2'h0;
			zero_cross_en_o <= 1'b0;
			volume_en_o <= 1'b0;
		end else begin
			output_format_i2s_o <= output_format_i2s_next;
			word_length_o <= word_length_next;
			adc_powered_down_o <= adc_powered_down_next;
			dac_powered_down_o <= dac_powered_down_next;
			codec_powered_down_o <= codec_powered_down_next;
			cal_start_o <= cal_start_next;
			mute_on_zero_en_o <= mute_on_zero_en_next;
			mute_ramp_rate_o <= mute_ramp_rate_next;
			zero_cross_en_o <= zero_cross_en_next;
			volume_en_o <= volume_en_next;
		end
	end
endmodule // apc_adc_ctrl

// *** rtl/apc_defs.vh ***
// constants for the adc path control and level monitor
// assumes a 100 MHz master clock and 20-bit two's complement samples
`ifndef APC_DEFS_VH
`define APC_DEFS_VH
`define APC_SAMPLE_W 20
`define APC_LEVEL_W 3
// peak level codes, higher code means louder
`define APC_LVL_LOW 3'h0
`define APC_LVL_DB6 3'h1
`define APC_LVL_DB5 3'h2
`define APC_LVL_DB4 3'h3
`define APC_LVL_DB3 3'h4
`define APC_LVL_DB2 3'h5
`define APC_LVL_DB1 3'h6
`define APC_LVL_CLIP 3'h7
// magnitude thresholds for -1..-6 dBFS on a 2^19 full scale
`define APC_THR_DB1 20'h72148
`define APC_THR_DB2 20'h65AC8
`define APC_THR_DB3 20'h5A9DF
`define APC_THR_DB4 20'h50C33
`define APC_THR_DB5 20'h47FAD
`define APC_THR_DB6 20'h4026E
`define APC_FULL_MAG 20'h7FFFF
// highpass pole shift: 2^-11 of fs gives about 3.7 Hz at 48 kHz
`define APC_HPF_SHIFT 11
`define APC_ACC_W 32
// interface word length codes
`define APC_WL_16 2'h0
`define APC_WL_18 2'h1
`define APC_WL_20 2'h2
// clock loss time in ns and its count at 10 ns
`define APC_CLK_PERIOD_NS 10
`define APC_CLKLOSS_NS 10000
`define APC_CLKLOSS_CYC (`APC_CLKLOSS_NS / `APC_CLK_PERIOD_NS)
`define APC_CLKLOSS_W 11
`endif

// *** rtl/apc_highpass.v ***
// first-order dc blocker, y = x - dc, dc tracks x at 2^-shift per sample
// assumes one sample strobe per sample period
`include "apc_defs.vh"
module apc_highpass (
	input wire mclk_i,
	input wire rstn_i,
	input wire bypass_i,
	input wire sample_valid_i,
	input wire [`APC_SAMPLE_W-1:0] sample_i,
	output wire [`APC_SAMPLE_W-1:0] sample_o
);
	reg [`APC_ACC_W-1:0] dc_reg;
	wire signed [`APC_ACC_W-1:0] x_ext;
	wire signed [`APC_ACC_W-1:0] dc_est;
	wire signed [`APC_ACC_W-1:0] diff;
	wire signed [`APC_ACC_W-1:0] sat;

	assign x_ext = {{(`APC_ACC_W-`APC_SAMPLE_W){sample_i[`APC_SAMPLE_W-1]}}, sample_i};
	assign dc_est = $signed(dc_reg) >>> `APC_HPF_SHIFT;
	assign diff = x_ext - dc_est;
	// saturate so a step never wraps into the opposite sign
	assign sat = (diff > $signed(32'h0007FFFF)) ? 32'h0007FFFF :
		(diff < $signed(32'hFFF80000)) ? 32'hFFF80000 : diff;

	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			dc_reg <= 32'h00000000;
		else if (sample_valid_i)
			dc_reg <= dc_reg + diff;
	end

	// estimate keeps running while bypassed so re-enabling has no step
	assign sample_o = bypass_i ? sample_i : sat[`APC_SAMPLE_W-1:0];
endmodule // apc_highpass

// *** rtl/apc_peak_detect.v ***
// per-channel peak level classifier with sticky maximum hold
// assumes one sample strobe per sample and a one-cycle clear pulse
`include "apc_defs.vh"
module apc_peak_detect (
	input wire mclk_i,
	input wire rstn_i,
	input wire enable_i,
	input wire sample_valid_i,
	input wire [`APC_SAMPLE_W-1:0] sample_i,
	input wire clear_i,
	output wire [`APC_LEVEL_W-1:0] level_o
);
	reg [`APC_LEVEL_W-1:0] level_reg;
	reg [`APC_LEVEL_W-1:0] level_next;
	reg [`APC_SAMPLE_W-1:0] mag;
	reg [`APC_LEVEL_W-1:0] cls;

	always @* begin
		mag = sample_i[`APC_SAMPLE_W-1] ? (~sample_i + 20'h00001) : sample_i;
		if (mag >= `APC_FULL_MAG)
			cls = `APC_LVL_CLIP;
		else if (mag >= `APC_THR_DB1)
			cls = `APC_LVL_DB1;
		else if (mag >= `APC_THR_DB2)
			cls = `APC_LVL_DB2;
		else if (mag >= `APC_THR_DB3)
			cls = `APC_LVL_DB3;
		else if (mag >= `APC_THR_DB4)
			cls = `APC_LVL_DB4;
		else if (mag >= `APC_THR_DB5)
			cls = `APC_LVL_DB5;
		else if (mag >= `APC_THR_DB6)
			cls = `APC_LVL_DB6;
		else
			cls = `APC_LVL_LOW;
	end

	// a sample in the clearing cycle still counts, so the set wins
	always @* begin
		level_next = clear_i ? `APC_LVL_LOW : level_reg;
		if (enable_i && sample_valid_i && cls > level_next)
			level_next = cls;
	end

	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			level_reg <= `APC_LVL_LOW;
		else
			level_reg <= level_next;
	end

	assign level_o = level_reg;
endmodule // apc_peak_detect
